// [core/tick_timer_pkg.sv]
// Purpose: Shared constants and carriers for the tick and year timers
// Assumes: 50 MHz system clock, synchronous active-high reset
// Notes:   Register offsets are byte addresses on the register port
//
// Overview of operation
// (R01) Tick enable set: tick interrupt every 10 ms; clear: no requests.
// (R02) Tick bit 7 is read-only pending; cleared by vector read or level-16 ack.
// (R03) Tick enable bit is read/write, cleared by power-up and I/O reset.
// (R04) Tick bits 31:8 and 3:0 read one, bit 5 reads zero, writes ignored.
// (R05) Tick bit 4 is read-only, reads one when the I/O module is absent.
// (R06) Tick requests use level 17, vector C0, highest at that level.
// (R07) Firmware places tick vector 2400 00C0 at boot ROM location 5C.
// (R08) Year counter: unsigned 32 bits, one count per 10 ms tick.
// (R09) Year counter advances only while non-zero; zero holds until written.
// (R10) Battery-low flag after initialization clears the year counter.
// (R11) Software clears battery-low by writing one after loading a time.
// (R12) Subset enable bit 6 gives 10 ms interrupts; cleared by resets. Code: SRST_IN and power-good loss while halted; IO_RESET_IN leaves it set.
// (R13) Subset bits 31:7 and 5:0 read zero; software writes them zero.
// (R14) Subset requests use level 16, vector C0, highest at that level.
// (R15) The 100 Hz tick divides the system clock to exactly 10 ms.
package tick_timer_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TICK_PERIOD_NS = 10000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [31:0] TICK_CTRL_MAIN_ADDR = 32'h1008_4010;
  localparam logic [31:0] TICK_CTRL_DIAG_ADDR = 32'h2008_4010;
  localparam logic [31:0] YEAR_TIME_MAIN_ADDR = 32'h1014_006C;
  localparam logic [31:0] YEAR_TIME_DIAG_ADDR = 32'h2014_006C;
  localparam logic [31:0] SUBSET_IPR_NUMBER   = 32'h0000_0018;

  localparam int unsigned TICK_PENDING_BIT = 7;
  localparam int unsigned TICK_ENABLE_BIT  = 6;
  localparam int unsigned IO_ABSENT_BIT    = 4;
  localparam int unsigned SUBSET_ENABLE_BIT = 6;

  localparam logic [31:0] TICK_CTRL_ONES   = 32'hFFFF_FF0F;
  localparam logic [31:0] YEAR_TIME_RESET  = 32'h0000_0000;
  localparam logic [31:0] READ_NONE        = 32'h0000_0000;

  localparam logic [4:0] TICK_LEVEL     = 5'h17;
  localparam logic [4:0] SUBSET_LEVEL   = 5'h16;
  localparam logic [7:0] TICK_VECTOR    = 8'hC0;
  localparam logic [7:0] SUBSET_VECTOR  = 8'hC0;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_TICK_CTRL,
    SEL_YEAR_TIME,
    SEL_SUBSET
  } reg_sel_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ipr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        req;
    logic [4:0]  level;
    logic [7:0]  vector;
    logic        top_priority;
  } irq_req_s;

endpackage

// [core/tick_divider.sv]
// Purpose: Free-running divider giving one pulse per tick period
// Assumes: DIVIDE of at least 2
// Notes:   Pulse lasts one clock, first pulse DIVIDE cycles after reset
module tick_divider #(
  parameter int unsigned DIVIDE = tick_timer_pkg::TICK_CYCLES,
  parameter int unsigned WIDTH  = $clog2(DIVIDE)
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tick
);

  localparam logic [WIDTH-1:0] LAST = WIDTH'(DIVIDE - 1);

  logic [WIDTH-1:0] count;

  // Exact period: counts 0 to DIVIDE-1 then wraps
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0; // [R15]
    end else begin
      count <= count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick <= 1'b0;
    end else begin
      tick <= (count == LAST); // [R15]
    end
  end

endmodule

// [core/tick_and_time_of_year_timers.sv]
// Purpose: Tick timer, subset interval clock and year time counter
// Assumes: Register strobes are one-cycle pulses synchronous to CLK_IN
// Notes:   Read data appears one cycle after the read strobe
module tick_and_time_of_year_timers #(
  parameter int unsigned TICK_DIVIDE = tick_timer_pkg::TICK_CYCLES
) (
  input  wire logic                     CLK_IN,
  input  wire logic                     SRST_IN,
  input  wire logic                     IO_RESET_IN,
  input  wire logic                     DC_POWER_GOOD_IN,
  input  wire logic                     PROC_HALTED_IN,
  input  wire logic                     IO_MODULE_ABSENT_IN,
  input  wire logic                     BATTERY_LOW_FLAG_IN,
  input  wire logic                     VECTOR_READ_PORT_TWO_IN,
  input  wire logic                     DIAG_ACK_LEVEL16_IN,
  input  wire tick_timer_pkg::reg_req_s REG_REQ_IN,
  output logic [31:0]                   REG_RDATA_OUT,
  output logic                          REG_RVALID_OUT,
  output tick_timer_pkg::irq_req_s      TICK_IRQ_OUT,
  output tick_timer_pkg::irq_req_s      SUBSET_IRQ_OUT
);

  logic        tick;
  logic        interrupt_enable;
  logic        tick_pending_flag;
  logic        subset_enable;
  logic        subset_pending;
  logic [31:0] year_time_counter;
  logic        power_good_prev;
  logic        battery_low_prev;
  logic        power_good_drop;
  logic        battery_low_rise;
  logic        year_time_running;
  logic        tick_ctrl_wr;
  logic        year_time_wr;
  logic        subset_wr;
  logic [31:0] next_read;
  tick_timer_pkg::reg_sel_e sel;

  // Both cores see the tick and year registers at their own address windows; the subset register is IPR 18 for both
  function automatic tick_timer_pkg::reg_sel_e decode(
    input logic        ipr,
    input logic [31:0] addr
  );
    tick_timer_pkg::reg_sel_e result;
    result = tick_timer_pkg::SEL_NONE;
    if (ipr) begin
      if (addr == tick_timer_pkg::SUBSET_IPR_NUMBER) begin
        result = tick_timer_pkg::SEL_SUBSET;
      end
    end else if (addr == tick_timer_pkg::TICK_CTRL_MAIN_ADDR ||
                 addr == tick_timer_pkg::TICK_CTRL_DIAG_ADDR) begin
      result = tick_timer_pkg::SEL_TICK_CTRL;
    end else if (addr == tick_timer_pkg::YEAR_TIME_MAIN_ADDR ||
                 addr == tick_timer_pkg::YEAR_TIME_DIAG_ADDR) begin
      result = tick_timer_pkg::SEL_YEAR_TIME;
    end
    return result;
  endfunction

  tick_divider #(
    .DIVIDE (TICK_DIVIDE)
  ) u_divider (
    .clk  (CLK_IN),
    .srst (SRST_IN),
    .tick (tick)
  );

  assign sel = decode(REG_REQ_IN.ipr, REG_REQ_IN.addr);
  assign tick_ctrl_wr = REG_REQ_IN.wr &&
                        (sel == tick_timer_pkg::SEL_TICK_CTRL);
  assign year_time_wr = REG_REQ_IN.wr &&
                        (sel == tick_timer_pkg::SEL_YEAR_TIME);
  assign subset_wr    = REG_REQ_IN.wr &&
                        (sel == tick_timer_pkg::SEL_SUBSET);

  // Edge detectors for the power-good and battery-low levels
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      power_good_prev  <= 1'b1;
      battery_low_prev <= 1'b0;
    end else begin
      power_good_prev  <= DC_POWER_GOOD_IN;
      battery_low_prev <= BATTERY_LOW_FLAG_IN;
    end
  end

  assign power_good_drop  = power_good_prev && !DC_POWER_GOOD_IN;
  // Prev resets low, so a flag already set at release counts as a rise
  assign battery_low_rise = BATTERY_LOW_FLAG_IN && !battery_low_prev;

  // Zero is the stopped state, not a count value
  assign year_time_running =
    (year_time_counter != tick_timer_pkg::YEAR_TIME_RESET); // [R09]

  // Tick enable: only bit 6 of a write is kept
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || IO_RESET_IN) begin
      interrupt_enable <= 1'b0; // [R03]
    end else if (tick_ctrl_wr) begin
      interrupt_enable <=
        REG_REQ_IN.wdata[tick_timer_pkg::TICK_ENABLE_BIT]; // [R03] [R04]
    end
  end

  // Set wins over clear so a tick on the acknowledge cycle is not lost
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN || IO_RESET_IN) begin
      tick_pending_flag <= 1'b0;
    end else if (tick && interrupt_enable) begin
      tick_pending_flag <= 1'b1; // [R01]
    end else if (VECTOR_READ_PORT_TWO_IN || DIAG_ACK_LEVEL16_IN) begin
      tick_pending_flag <= 1'b0; // [R02]
    end else if (!interrupt_enable) begin
      // Disabling drops a stale pending tick as well
      tick_pending_flag <= 1'b0; // [R01]
    end
  end

  // Subset enable cleared on power-good loss only while halted
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      subset_enable <= 1'b0; // [R12]
    end else if (power_good_drop && PROC_HALTED_IN) begin
      subset_enable <= 1'b0; // [R12]
    end else if (subset_wr) begin
      subset_enable <=
        REG_REQ_IN.wdata[tick_timer_pkg::SUBSET_ENABLE_BIT]; // [R13]
    end
  end

  // Level-16 acknowledge also retires the subset request
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      subset_pending <= 1'b0;
    end else if (tick && subset_enable) begin
      subset_pending <= 1'b1; // [R12]
    end else if (DIAG_ACK_LEVEL16_IN || !subset_enable) begin
      subset_pending <= 1'b0; // [R12]
    end
  end

  // Battery clear beats a same-cycle write; write beats the tick
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      year_time_counter <= tick_timer_pkg::YEAR_TIME_RESET;
    end else if (battery_low_rise) begin
      year_time_counter <= tick_timer_pkg::YEAR_TIME_RESET; // [R10]
    end else if (year_time_wr) begin
      year_time_counter <= REG_REQ_IN.wdata; // [R09]
    end else if (tick && year_time_running) begin
      year_time_counter <= year_time_counter + 32'h0000_0001; // [R08] [R09]
    end
  end

  // Read multiplexer
  always_comb begin
    next_read = tick_timer_pkg::READ_NONE;
    case (sel)
      tick_timer_pkg::SEL_TICK_CTRL: begin
        next_read = tick_timer_pkg::TICK_CTRL_ONES; // [R04]
        next_read[tick_timer_pkg::TICK_PENDING_BIT] =
          tick_pending_flag; // [R02]
        next_read[tick_timer_pkg::TICK_ENABLE_BIT] =
          interrupt_enable; // [R03]
        next_read[tick_timer_pkg::IO_ABSENT_BIT] =
          IO_MODULE_ABSENT_IN; // [R05]
      end
      tick_timer_pkg::SEL_YEAR_TIME: begin
        next_read = year_time_counter; // [R08]
      end
      tick_timer_pkg::SEL_SUBSET: begin
        next_read[tick_timer_pkg::SUBSET_ENABLE_BIT] =
          subset_enable; // [R13]
      end
      default: begin
        next_read = tick_timer_pkg::READ_NONE;
      end
    endcase
  end

  // Unmapped reads still answer, with zero
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      REG_RDATA_OUT  <= tick_timer_pkg::READ_NONE;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      // Data holds between reads; only the valid flag pulses
      REG_RVALID_OUT <= REG_REQ_IN.rd;
      if (REG_REQ_IN.rd) begin
        REG_RDATA_OUT <= next_read;
      end
    end
  end

  // Vector value itself comes from the boot ROM, not from here
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      TICK_IRQ_OUT.req          <= 1'b0;
      TICK_IRQ_OUT.level        <= 5'h00;
      TICK_IRQ_OUT.vector       <= 8'h00;
      TICK_IRQ_OUT.top_priority <= 1'b0;
    end else begin
      TICK_IRQ_OUT.req          <= tick_pending_flag; // [R01] [R02]
      TICK_IRQ_OUT.level        <= tick_timer_pkg::TICK_LEVEL; // [R06]
      TICK_IRQ_OUT.vector       <= tick_timer_pkg::TICK_VECTOR; // [R06] [R07]
      TICK_IRQ_OUT.top_priority <= 1'b1; // [R06]
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      SUBSET_IRQ_OUT.req          <= 1'b0;
      SUBSET_IRQ_OUT.level        <= 5'h00;
      SUBSET_IRQ_OUT.vector       <= 8'h00;
      SUBSET_IRQ_OUT.top_priority <= 1'b0;
    end else begin
      SUBSET_IRQ_OUT.req          <= subset_pending; // [R12]
      SUBSET_IRQ_OUT.level        <= tick_timer_pkg::SUBSET_LEVEL; // [R14]
      SUBSET_IRQ_OUT.vector       <= tick_timer_pkg::SUBSET_VECTOR; // [R14]
      SUBSET_IRQ_OUT.top_priority <= 1'b1; // [R14]
    end
  end

endmodule

// [verification/tick_timer_properties.sv]
// Purpose: Port properties of the tick and year timers
// Assumes: One clock, synchronous reset
// Notes:   Gap counters time the request rises
module tick_timer_properties #(
  parameter int unsigned TICK_DIVIDE = 20
) (
  input wire logic                     CLK_IN,
  input wire logic                     SRST_IN,
  input wire logic                     IO_RESET_IN,
  input wire logic                     IO_MODULE_ABSENT_IN,
  input wire tick_timer_pkg::reg_req_s REG_REQ_IN,
  input wire logic [31:0]              REG_RDATA_OUT,
  input wire logic                     REG_RVALID_OUT,
  input wire tick_timer_pkg::irq_req_s TICK_IRQ_OUT,
  input wire tick_timer_pkg::irq_req_s SUBSET_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  int unsigned tgap;
  int unsigned sgap;
  // Rises land only on divider ticks, so never closer than one period
  always_ff @(posedge CLK_IN) begin
    tgap <= (SRST_IN || $rose(TICK_IRQ_OUT.req)) ? 1 : tgap + 1;
  end
  always_ff @(posedge CLK_IN) begin
    sgap <= (SRST_IN || $rose(SUBSET_IRQ_OUT.req)) ? 1 : sgap + 1;
  end
  sequence tick_rd;
    REG_REQ_IN.rd && !REG_REQ_IN.ipr &&
      REG_REQ_IN.addr == tick_timer_pkg::TICK_CTRL_MAIN_ADDR;
  endsequence
  sequence sub_rd;
    REG_REQ_IN.rd && REG_REQ_IN.ipr && REG_REQ_IN.addr == 32'h0000_0018;
  endsequence
  tick_field_a: assert property (
    TICK_IRQ_OUT.req |-> TICK_IRQ_OUT == {1'b1, 5'h17, 8'hC0, 1'b1})
    else $error("tick request fields wrong");
  sub_field_a: assert property (
    SUBSET_IRQ_OUT.req |-> SUBSET_IRQ_OUT == {1'b1, 5'h16, 8'hC0, 1'b1})
    else $error("subset request fields wrong");
  tick_gap_a: assert property (
    $rose(TICK_IRQ_OUT.req) |-> tgap >= TICK_DIVIDE)
    else $error("tick requests too close");
  sub_gap_a: assert property (
    $rose(SUBSET_IRQ_OUT.req) |-> sgap >= TICK_DIVIDE)
    else $error("subset requests too close");
  rd_answer_a: assert property (
    REG_REQ_IN.rd |=> REG_RVALID_OUT)
    else $error("read not answered");
  tick_fmt_a: assert property (
    tick_rd |=> REG_RDATA_OUT[31:8] == 24'hFFFFFF &&
      REG_RDATA_OUT[5:0] == {1'b0, $past(IO_MODULE_ABSENT_IN), 4'hF})
    else $error("tick register fixed bits wrong");
  sub_fmt_a: assert property (
    sub_rd |=> (REG_RDATA_OUT & 32'hFFFF_FFBF) == 32'h0000_0000)
    else $error("subset unused bits not zero");
  io_reset_a: assert property (
    IO_RESET_IN [*2] |-> ##2 !TICK_IRQ_OUT.req)
    else $error("tick request survives io reset");
endmodule

bind tick_and_time_of_year_timers tick_timer_properties #(
  .TICK_DIVIDE(TICK_DIVIDE)
) props (.CLK_IN, .SRST_IN, .IO_RESET_IN, .IO_MODULE_ABSENT_IN,
  .REG_REQ_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .TICK_IRQ_OUT,
  .SUBSET_IRQ_OUT);

// [verification/core_model.sv]
// Purpose: Core model for register cycles and acks
// Assumes: Changes land 1 ns after the edge
// Notes:   Idle address and data lines show the inverse of the last value
module core_model (
  input  wire logic                clk,
  input  wire logic                rvalid,
  input  wire logic [31:0]         rdata,
  output tick_timer_pkg::reg_req_s req,
  output logic                     vec,
  output logic                     diag
);
  timeunit 1ns;
  timeprecision 1ps;
  // Tick vector held in the boot table
  localparam logic [31:0] ROM_5C = 32'h2400_00C0;
  initial req = '0;
  initial vec = 1'b0;
  initial diag = 1'b0;
  task automatic cyc(input logic r, i, input logic [31:0] a, d);
    @(posedge clk);
    #1;
    req = {r, !r, i, a, i ? d & 32'h0000_0040 : d};
    @(posedge clk);
    #1;
    req = {3'b000, ~req.addr, ~req.wdata};
  endtask
  task automatic rd(input logic i, input logic [31:0] a,
                    output logic [31:0] d);
    cyc(1'b1, i, a, 32'h0000_0000);
    d = rvalid ? rdata : ~rdata;
  endtask
  task automatic ack(input logic dg);
    @(posedge clk);
    #1;
    {diag, vec} = dg ? 2'b10 : 2'b01;
    @(posedge clk);
    #1;
    {diag, vec} = 2'b00;
  endtask
endmodule

// [verification/tick_and_time_of_year_timers_tb.sv]
// Purpose: Self-checking bench for the tick and year timers
// Assumes: Divider shortened to 20 cycles
// Notes:   Core cycles come from the partner model
module tick_and_time_of_year_timers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DIV = 20;
  localparam logic [31:0] TA = tick_timer_pkg::TICK_CTRL_MAIN_ADDR;
  localparam logic [31:0] YA = tick_timer_pkg::YEAR_TIME_MAIN_ADDR;
  localparam logic [31:0] SA = 32'h0000_0018;
  logic clk, srst, io_rst, dc_good, halted, absent, batt, rvalid, vec, diag;
  logic [31:0]              rdata, v;
  tick_timer_pkg::reg_req_s req;
  tick_timer_pkg::irq_req_s tick_irq, sub_irq;
  int miscompares = 0, checks_done = 0, cycles = 0;
  tick_and_time_of_year_timers #(.TICK_DIVIDE(DIV)) dut (
    .CLK_IN(clk), .SRST_IN(srst), .IO_RESET_IN(io_rst),
    .DC_POWER_GOOD_IN(dc_good), .PROC_HALTED_IN(halted),
    .IO_MODULE_ABSENT_IN(absent), .BATTERY_LOW_FLAG_IN(batt),
    .VECTOR_READ_PORT_TWO_IN(vec), .DIAG_ACK_LEVEL16_IN(diag),
    .REG_REQ_IN(req), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .TICK_IRQ_OUT(tick_irq), .SUBSET_IRQ_OUT(sub_irq));
  core_model cpu (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req),
    .vec(vec), .diag(diag));
  task automatic check(input string n, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_req(input logic s);
    for (int i = 0; i < 3 * DIV; i++) begin
      if ((s ? sub_irq.req : tick_irq.req) === 1'b1) break;
      idle(1);
    end
    check("irq", s ? sub_irq : tick_irq,
      {1'b1, s ? 5'h16 : 5'h17, 8'hC0, 1'b1});
  endtask
  task automatic test_regs();
    cpu.rd(1'b0, TA, v);
    check("tick", v, 32'hFFFF_FF0F);
    cpu.cyc(1'b0, 1'b0, TA, 32'h0000_00A0);
    cpu.rd(1'b0, TA, v);
    check("tick_ro", v, 32'hFFFF_FF0F);
    absent = 1'b1;
    cpu.cyc(1'b0, 1'b0, TA, 32'h0000_0040);
    cpu.rd(1'b0, TA, v);
    check("tick_en", v & 32'hFFFF_FF7F, 32'hFFFF_FF5F);
    cpu.rd(1'b0, 32'h1008_4014, v);
    check("unmapped", v, 32'h0000_0000);
    cpu.rd(1'b1, SA, v);
    check("subset", v, 32'h0000_0000);
    cpu.cyc(1'b0, 1'b0, TA, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic test_tick();
    cpu.cyc(1'b0, 1'b0, TA, 32'h0000_0040);
    wait_req(1'b0);
    cpu.rd(1'b0, TA, v);
    check("pending", v[7], 1'b1);
    cpu.ack(1'b0);
    idle(2);
    check("vec_ack", tick_irq.req, 1'b0);
    wait_req(1'b0);
    cpu.ack(1'b1);
    idle(2);
    check("diag_ack", tick_irq.req, 1'b0);
    wait_req(1'b0);
    io_rst = 1'b1;
    idle(2);
    io_rst = 1'b0;
    check("io_rst", tick_irq.req, 1'b0);
    idle(3 * DIV);
    check("tick_off", tick_irq.req, 1'b0);
    $display("test tick done");
  endtask
  task automatic test_year();
    cpu.cyc(1'b0, 1'b0, YA, 32'h0000_0000);
    idle(2 * DIV);
    cpu.rd(1'b0, YA, v);
    check("year_zero", v, 32'h0000_0000);
    cpu.cyc(1'b0, 1'b0, YA, 32'h0000_0005);
    idle(4 * DIV);
    cpu.rd(1'b0, YA, v);
    check("year_run", v - 32'h9 <= 32'h1, 1'b1);
    batt = 1'b1;
    idle(3);
    cpu.rd(1'b0, YA, v);
    check("year_batt", v, 32'h0000_0000);
    cpu.cyc(1'b0, 1'b0, YA, 32'h0000_0007);
    cpu.rd(1'b0, YA, v);
    check("year_load", v - 32'h7 <= 32'h1, 1'b1);
    batt = 1'b0;
    $display("test year done");
  endtask
  task automatic test_subset();
    cpu.cyc(1'b0, 1'b1, SA, 32'hFFFF_FFFF);
    cpu.rd(1'b1, SA, v);
    check("subset_en", v, 32'h0000_0040);
    wait_req(1'b1);
    cpu.ack(1'b1);
    idle(2);
    check("subset_ack", sub_irq.req, 1'b0);
    dc_good = 1'b0;
    idle(2);
    dc_good = 1'b1;
    cpu.rd(1'b1, SA, v);
    check("subset_off", v, 32'h0000_0000);
    idle(3 * DIV);
    check("subset_quiet", sub_irq.req, 1'b0);
    halted = 1'b0;
    cpu.cyc(1'b0, 1'b1, SA, 32'h0000_0040);
    dc_good = 1'b0;
    idle(2);
    dc_good = 1'b1;
    cpu.rd(1'b1, SA, v);
    check("subset_run", v, 32'h0000_0040);
    wait_req(1'b1);
    cpu.cyc(1'b0, 1'b1, SA, 32'h0000_0000);
    halted = 1'b1;
    $display("test subset done");
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {srst, io_rst, dc_good, halted, absent, batt} = 6'b101100;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    test_regs();
    test_tick();
    test_year();
    test_subset();
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
endmodule
